// ==== caeh_defs.vh ====
`ifndef CAEH_DEFS_VH
`define CAEH_DEFS_VH
`define CAEH_AW 8
`define CAEH_DW 16
`define CAEH_OFS_CTRL 8'h00
`define CAEH_OFS_STAT 8'h04
`define CAEH_OFS_XERR 8'h08
`define CAEH_OFS_DIAG 8'h0c
`define CAEH_CTRL_LIM 7:0
`define CAEH_CTRL_USER 8
`define CAEH_CTRL_RESTART 15
`define CAEH_CTRL_RST 9'h000
`define CAEH_START_INTERP 16'h0006
`define CAEH_START_USER 16'h0008
`define CAEH_RETRY_LIMIT 20
`define CAEH_RETRY_W 5
`define CAEH_DEB_NS 10000
`define CAEH_CLK_KHZ 25000
`define CAEH_OL_RUN 2'h0
`define CAEH_OL_DRAIN 2'h1
`define CAEH_OL_OFF 2'h2
`endif

// ==== caeh_key_filter.v ====
`timescale 1ns/1ns
`include "caeh_defs.vh"
// two-stage synchroniser followed by a stability filter for the key pin
module caeh_key_filter #(
    parameter integer DEB_CYCLES = 250
) (
    input wire ref_clk_i, // system clock
    input wire rst_i, // synchronous reset, active high
    input wire key_i, // raw key pin, high in disable position
    output reg key_o // filtered key level
);
    localparam integer CW = 16;
    reg meta_r;
    reg sync_r;
    reg [CW-1:0] cnt_r;
    reg [CW-1:0] cnt_nxt;
    reg key_nxt;

    // first flop feeds only the second
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
        end else begin
            meta_r <= key_i;
            sync_r <= meta_r;
        end
    end

    // a level must hold for the full window before it is believed
    always @* begin
        cnt_nxt = cnt_r;
        key_nxt = key_o;
        if (sync_r == key_o) begin
            cnt_nxt = {CW{1'b0}};
        end else if (cnt_r == DEB_CYCLES[CW-1:0] - 16'h0001) begin
            key_nxt = sync_r;
            cnt_nxt = {CW{1'b0}};
        end else begin
            cnt_nxt = cnt_r + 16'h0001;
        end
    end

    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            cnt_r <= {CW{1'b0}};
            key_o <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            key_o <= key_nxt;
        end
    end
endmodule

// ==== caeh_top.v ====
`timescale 1ns/1ns
`include "caeh_defs.vh"
module caeh_top #(
    parameter integer DEB_NS = `CAEH_DEB_NS,
    parameter integer RETRY_LIMIT = `CAEH_RETRY_LIMIT
) (
    input wire ref_clk_i, // system clock, 25 MHz
    input wire rst_i, // power-up reset, synchronous, active high
    input wire [`CAEH_AW-1:0] reg_addr_i, // register byte address
    input wire [`CAEH_DW-1:0] reg_wdata_i, // register write data
    input wire reg_wr_i, // register write strobe
    input wire reg_rd_i, // register read strobe
    output reg [`CAEH_DW-1:0] reg_rdata_o, // read data, cycle after strobe
    input wire disable_key_i, // operator key pin, high = disable
    input wire chan_irq_pending_i, // channel attachment work still pending
    input wire chan_avail_i, // channel free for reattachment
    input wire start_wr_i, // host wrote the start register
    input wire [15:0] start_val_i, // start register value
    input wire interp_step_i, // interpreter fetched a new instruction
    input wire interp_repeat_i, // interpreter repeated the same instruction
    input wire interp_done_i, // interpreter finished normally
    input wire branch_oor_i, // branch target outside control space
    input wire term_stop_i, // transfer stopped normally
    input wire stop_end_with_error_i, // stop with error
    input wire count_exhausted_end_i, // count ran out normally
    input wire count_exhausted_with_error_i, // count ran out with error
    input wire host_early_disconnect_i, // host ended transfer early
    input wire host_early_disconnect_with_error_i, // early end plus error
    input wire xfer_to_host_i, // transfer direction, high = to host
    input wire [7:0] xfer_err_i, // raw transfer error byte
    input wire iface_disc_i, // interface disconnect from channel
    input wire cmd_seq_active_i, // a command sequence is in progress
    input wire data_done_i, // data phase of current command complete
    input wire adapter_fault_i, // adapter_fault_handler entry
    input wire [7:0] fault_code_i, // code with the fault
    input wire sel_reset_i, // selective reset from channel
    input wire [7:0] sel_addr_i, // device address of selective reset
    input wire sel_not_ready_i, // addressed device is not ready
    input wire handler_ack_i, // device handler saw reset notice
    input wire adapter_parity_i, // adapter logic parity error
    input wire err_irq_i, // error interrupt
    input wire err_cause_i, // error interrupt has an identified cause
    output wire chan_enable_o, // channel communication allowed
    output reg interp_run_o, // interpreter running
    output reg user_dispatch_o, // pulse: run user code
    output reg xfer_done_o, // pulse: transfer terminated
    output reg retry_o, // pulse: hardware retry
    output reg abort_o, // pulse: abort channel activity
    output reg sreset_notify_o, // reset notice to handler
    output reg [7:0] sreset_addr_o, // address of that notice
    output wire reattach_req_o, // ending status waiting for channel
    output reg status_valid_o, // pulse: ending status presented
    output reg status_de_o, // device end in presented status
    output reg status_uc_o // unit check in presented status
);
    localparam integer DEB_CYC = (DEB_NS * `CAEH_CLK_KHZ + 999999) / 1000000;
    localparam RL = RETRY_LIMIT[`CAEH_RETRY_W-1:0];

    wire key_dis;
    reg key_dis_d_r;
    reg [8:0] ctrl_r;
    reg [1:0] ol_state_r;
    reg [1:0] ol_state_nxt;
    reg err_off_r;
    reg [7:0] rep_cnt_r;
    reg [`CAEH_RETRY_W-1:0] retry_cnt_r;
    reg [7:0] xerr_r;
    reg xdir_r;
    reg [7:0] fcode_r;
    reg sr_wait_r;
    reg end_pend_r;
    reg end_uc_r;
    reg set_de;
    reg set_uc;
    reg go_err_off;
    wire chan_ok;
    wire limit_hit;
    wire early;
    wire early_err;
    wire stop_any;
    wire err_any;
    wire restart;
    wire int_par;
    wire bus_par;
    wire adp_sus;

    caeh_key_filter #(
        .DEB_CYCLES(DEB_CYC)
    ) u_key (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .key_i(disable_key_i),
        .key_o(key_dis)
    );

    // register address match
    function hit;
        input [`CAEH_AW-1:0] a;
        input [`CAEH_AW-1:0] ofs;
        begin
            hit = (a == ofs);
        end
    endfunction

    // channel traffic only while enabled, not error off-line, no reset open
    assign chan_ok = !err_off_r && (ol_state_r != `CAEH_OL_OFF) && !sr_wait_r;
    assign restart = reg_wr_i && hit(reg_addr_i, `CAEH_OFS_CTRL)
        && reg_wdata_i[`CAEH_CTRL_RESTART];
    assign early = chan_ok && host_early_disconnect_i;
    assign early_err = chan_ok && host_early_disconnect_with_error_i;
    assign stop_any = chan_ok && (term_stop_i || stop_end_with_error_i
        || count_exhausted_end_i || count_exhausted_with_error_i);
    assign err_any = chan_ok && (stop_end_with_error_i || count_exhausted_with_error_i
        || early_err || (err_irq_i && err_cause_i));
    // loop check; a zero limit never trips
    assign limit_hit = interp_run_o && interp_repeat_i
        && (ctrl_r[`CAEH_CTRL_LIM] != 8'h00)
        && (rep_cnt_r >= ctrl_r[`CAEH_CTRL_LIM]);
    assign reattach_req_o = end_pend_r && chan_ok;

    // error byte decode by direction
    assign int_par = xerr_r[0] && xdir_r;
    assign bus_par = xerr_r[1] && !xdir_r;
    assign adp_sus = (xerr_r != 8'h00) && !int_par && !bus_par;

    // ending status requests from all sources
    always @* begin
        set_de = 1'b0;
        set_uc = 1'b0;
        if (limit_hit || (chan_ok && interp_run_o && branch_oor_i)) begin
            set_de = 1'b1;
        end
        if (chan_ok && interp_run_o && interp_done_i) begin
            set_de = 1'b1;
        end
        if (chan_ok && start_wr_i) begin
            if (start_val_i == `CAEH_START_USER && !ctrl_r[`CAEH_CTRL_USER]) begin
                set_de = 1'b1;
            end else if (start_val_i != `CAEH_START_USER
                && start_val_i != `CAEH_START_INTERP) begin
                set_de = 1'b1;
                set_uc = 1'b1;
            end
        end
        if (early || early_err) begin
            set_de = 1'b1;
            set_uc = set_uc || early_err;
        end
        if (chan_ok && iface_disc_i && cmd_seq_active_i && data_done_i) begin
            set_de = 1'b1;
        end
    end

    // off-line sequence for the operator key
    always @* begin
        ol_state_nxt = ol_state_r;
        case (ol_state_r)
            `CAEH_OL_RUN: begin
                if (key_dis && !key_dis_d_r) begin
                    ol_state_nxt = `CAEH_OL_DRAIN;
                end
            end
            `CAEH_OL_DRAIN: begin
                if (!key_dis) begin
                    ol_state_nxt = `CAEH_OL_RUN;
                end else if (!chan_irq_pending_i) begin
                    ol_state_nxt = `CAEH_OL_OFF;
                end
            end
            `CAEH_OL_OFF: begin
                if (!key_dis) begin
                    ol_state_nxt = `CAEH_OL_RUN;
                end
            end
            default: begin
                ol_state_nxt = `CAEH_OL_RUN;
            end
        endcase
    end

    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            ol_state_r <= `CAEH_OL_RUN;
            key_dis_d_r <= 1'b0;
        end else begin
            ol_state_r <= ol_state_nxt;
            key_dis_d_r <= key_dis;
        end
    end

    // error off-line causes
    always @* begin
        go_err_off = 1'b0;
        if (adapter_fault_i) begin
            go_err_off = 1'b1;
        end
        if (adapter_parity_i && (retry_cnt_r >= RL - 5'h01)) begin // at limit, stays failed
            go_err_off = 1'b1;
        end
    end

    // error off-line holds until a restart; a fault in the restart cycle wins
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            err_off_r <= 1'b0;
            fcode_r <= 8'h00;
        end else begin
            if (go_err_off) begin
                err_off_r <= 1'b1;
            end else if (restart) begin
                err_off_r <= 1'b0;
            end
            if (adapter_fault_i && !err_off_r) begin
                fcode_r <= fault_code_i;
            end
        end
    end

    // parity retries since power-up, saturating, reset only
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            retry_cnt_r <= {`CAEH_RETRY_W{1'b0}};
            retry_o <= 1'b0;
        end else begin
            retry_o <= 1'b0;
            if (adapter_parity_i && !err_off_r) begin
                retry_o <= (retry_cnt_r < RL - 5'h01);
                if (retry_cnt_r != RL) begin
                    retry_cnt_r <= retry_cnt_r + 5'h01;
                end
            end
        end
    end

    // control register and start register dispatch
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            ctrl_r <= `CAEH_CTRL_RST;
            interp_run_o <= 1'b0;
            user_dispatch_o <= 1'b0;
            rep_cnt_r <= 8'h00;
        end else begin
            user_dispatch_o <= 1'b0;
            if (reg_wr_i && hit(reg_addr_i, `CAEH_OFS_CTRL)) begin
                ctrl_r <= reg_wdata_i[8:0];
            end
            if (chan_ok && start_wr_i && start_val_i == `CAEH_START_USER) begin
                user_dispatch_o <= ctrl_r[`CAEH_CTRL_USER];
            end
            if (limit_hit || !chan_ok || branch_oor_i || interp_done_i) begin
                interp_run_o <= 1'b0;
            end else if (start_wr_i && start_val_i == `CAEH_START_INTERP) begin
                interp_run_o <= 1'b1;
            end
            if (interp_step_i || !interp_run_o) begin
                rep_cnt_r <= 8'h00;
            end else if (interp_repeat_i && rep_cnt_r != 8'hff) begin
                rep_cnt_r <= rep_cnt_r + 8'h01;
            end
        end
    end

    // transfer termination and error byte capture
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            xfer_done_o <= 1'b0;
            xerr_r <= 8'h00;
            xdir_r <= 1'b0;
        end else begin
            xfer_done_o <= stop_any || early || early_err;
            if (err_any) begin
                xerr_r <= xfer_err_i;
                xdir_r <= xfer_to_host_i;
            end
        end
    end

    // selective reset: abort, notify handler, hold channel until ack
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            sr_wait_r <= 1'b0;
            abort_o <= 1'b0;
            sreset_notify_o <= 1'b0;
            sreset_addr_o <= 8'h00;
        end else begin
            abort_o <= 1'b0;
            if (sel_reset_i && !err_off_r && ol_state_r != `CAEH_OL_OFF
                && !sel_not_ready_i) begin
                abort_o <= 1'b1;
                sr_wait_r <= 1'b1;
                sreset_notify_o <= 1'b1;
                sreset_addr_o <= sel_addr_i;
            end else if (sr_wait_r && handler_ack_i) begin
                sr_wait_r <= 1'b0;
                sreset_notify_o <= 1'b0;
            end
        end
    end

    // ending status held until the channel is free, cleared while chan_ok is low; new request wins
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            end_pend_r <= 1'b0;
            end_uc_r <= 1'b0;
            status_valid_o <= 1'b0;
            status_de_o <= 1'b0;
            status_uc_o <= 1'b0;
        end else begin
            status_valid_o <= 1'b0;
            if (!chan_ok) begin
                end_pend_r <= 1'b0;
                end_uc_r <= 1'b0;
            end else if (set_de) begin
                end_pend_r <= 1'b1;
                end_uc_r <= set_uc || (end_pend_r && !chan_avail_i && end_uc_r);
            end else if (end_pend_r && chan_avail_i) begin
                end_pend_r <= 1'b0;
                end_uc_r <= 1'b0;
            end
            if (chan_ok && end_pend_r && chan_avail_i) begin
                status_valid_o <= 1'b1;
                status_de_o <= 1'b1;
                status_uc_o <= end_uc_r;
            end
        end
    end

    // read port, data one cycle after the strobe
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            reg_rdata_o <= 16'h0000;
        end else if (reg_rd_i) begin
            if (hit(reg_addr_i, `CAEH_OFS_CTRL)) begin
                reg_rdata_o <= {7'h00, ctrl_r};
            end else if (hit(reg_addr_i, `CAEH_OFS_STAT)) begin
                reg_rdata_o <= {8'h00, (retry_cnt_r == RL), adp_sus, bus_par, int_par,
                    sr_wait_r, ol_state_r == `CAEH_OL_DRAIN, key_dis, err_off_r};
            end else if (hit(reg_addr_i, `CAEH_OFS_XERR)) begin
                reg_rdata_o <= {8'h00, xerr_r};
            end else if (hit(reg_addr_i, `CAEH_OFS_DIAG)) begin
                reg_rdata_o <= {3'h0, retry_cnt_r, fcode_r};
            end else begin
                reg_rdata_o <= 16'h0000;
            end
        end else begin
            reg_rdata_o <= 16'h0000;
        end
    end

    assign chan_enable_o = chan_ok;
endmodule

// ==== caeh_asserts.sv ====
`timescale 1ns/1ns
module caeh_asserts (
    input wire ref_clk_i, // clock
    input wire rst_i, // reset
    input wire start_wr_i, // start write
    input wire [15:0] start_val_i, // start value
    input wire branch_oor_i, // bad branch
    input wire host_early_disconnect_i, // early end
    input wire host_early_disconnect_with_error_i, // early end, error
    input wire sel_reset_i, // selective reset
    input wire sel_not_ready_i, // device not ready
    input wire handler_ack_i, // handler ack
    input wire adapter_parity_i, // parity error
    input wire chan_avail_i, // channel free
    input wire chan_enable_o, // channel allowed
    input wire interp_run_o, // interpreter on
    input wire xfer_done_o, // transfer done
    input wire retry_o, // retry pulse
    input wire abort_o, // abort pulse
    input wire sreset_notify_o, // reset notice
    input wire status_valid_o, // status shown
    input wire status_de_o, // device end
    input wire status_uc_o // unit check
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    // channel reaction to selective reset, ack and stray resets
    chk_sel_abort: assert property (
        sel_reset_i && !sel_not_ready_i && chan_enable_o |=> abort_o && !chan_enable_o)
        else $error("selective reset did not abort");
    chk_abort_pulse: assert property (abort_o |=> !abort_o)
        else $error("abort longer than one cycle");
    chk_ack_resume: assert property (sreset_notify_o && handler_ack_i |=> !sreset_notify_o)
        else $error("reset notice not withdrawn");
    chk_ready_ignore: assert property (
        sel_reset_i && sel_not_ready_i && !sreset_notify_o |=> !abort_o && !sreset_notify_o)
        else $error("reset to idle device acted on");
    // transfer endings and status
    chk_early_end: assert property (chan_enable_o && host_early_disconnect_i |=> xfer_done_o)
        else $error("early end not terminated");
    chk_early_uc: assert property (
        chan_enable_o && host_early_disconnect_with_error_i && chan_avail_i
        ##1 chan_avail_i && chan_enable_o |=> status_valid_o && status_de_o && status_uc_o)
        else $error("early end status wrong");
    chk_off_quiet: assert property (!chan_enable_o && host_early_disconnect_i |=> !xfer_done_o)
        else $error("event taken while off-line");
    // parity retry, start dispatch and branch stop
    chk_retry_next: assert property (
        adapter_parity_i && chan_enable_o |=> retry_o || !chan_enable_o)
        else $error("parity error without retry");
    chk_start_interp: assert property (
        start_wr_i && chan_enable_o && start_val_i == 16'h0006 |=> interp_run_o)
        else $error("interpreter not started");
    chk_branch_stop: assert property (
        branch_oor_i && chan_enable_o && interp_run_o |=> !interp_run_o)
        else $error("bad branch did not stop");
    cover property (abort_o);
    cover property (retry_o);
    cover property (status_valid_o && status_uc_o);
endmodule
bind caeh_top caeh_asserts i_chk (.*);

// ==== caeh_chan_model.sv ====
`timescale 1ns/1ns
module caeh_chan_model (
    input wire ref_clk_i, // clock
    input wire rst_i, // reset
    input wire slow_i, // late acknowledge
    input wire hold_i, // channel busy
    input wire sreset_notify_o, // reset notice
    output logic chan_avail_i, // channel free
    output logic handler_ack_i // handler ack
);
    logic [3:0] cnt_r;
    // channel frees a cycle after the bench lets it; handler acks a notice late or soon
    always @(posedge ref_clk_i) begin
        chan_avail_i <= !hold_i && !rst_i;
        if (rst_i || !sreset_notify_o || handler_ack_i) begin
            cnt_r <= 4'h0;
            handler_ack_i <= 1'b0;
        end else begin
            cnt_r <= cnt_r + 4'h1;
            handler_ack_i <= (cnt_r == (slow_i ? 4'h5 : 4'h0));
        end
    end
endmodule

// ==== tb_top.sv ====
`timescale 1ns/1ns
`include "caeh_defs.vh"
module tb_top;
    logic ref_clk_i, rst_i, reg_wr_i, reg_rd_i, disable_key_i, chan_irq_pending_i;
    logic xfer_to_host_i, cmd_seq_active_i, data_done_i, sel_not_ready_i, err_cause_i;
    logic slow_i, hold_i, chan_avail_i, handler_ack_i;
    logic start_wr_i, interp_step_i, interp_repeat_i, interp_done_i, branch_oor_i;
    logic term_stop_i, stop_end_with_error_i, count_exhausted_end_i;
    logic count_exhausted_with_error_i, host_early_disconnect_i, iface_disc_i;
    logic host_early_disconnect_with_error_i, adapter_fault_i, sel_reset_i;
    logic adapter_parity_i, err_irq_i;
    logic [7:0] reg_addr_i, xfer_err_i, fault_code_i, sel_addr_i, sreset_addr_o;
    logic [15:0] reg_wdata_i, start_val_i, reg_rdata_o, ev, rdv;
    logic chan_enable_o, interp_run_o, user_dispatch_o, xfer_done_o, retry_o, abort_o;
    logic sreset_notify_o, reattach_req_o, status_valid_o, status_de_o, status_uc_o;
    int mismatches = 0, comparisons = 0, cyc = 0;
    localparam logic [15:0] p_start = 16'h0001, p_step = 16'h0002, p_rep = 16'h0004;
    localparam logic [15:0] p_boor = 16'h0010, p_stope = 16'h0040, p_zce = 16'h0100;
    localparam logic [15:0] p_hed = 16'h0200, p_hede = 16'h0400, p_disc = 16'h0800;
    localparam logic [15:0] p_flt = 16'h1000, p_sel = 16'h2000, p_par = 16'h4000;
    localparam logic [15:0] p_irq = 16'h8000;
    // event pulses travel as one vector
    assign {err_irq_i, adapter_parity_i, sel_reset_i, adapter_fault_i, iface_disc_i,
        host_early_disconnect_with_error_i, host_early_disconnect_i,
        count_exhausted_with_error_i, count_exhausted_end_i, stop_end_with_error_i,
        term_stop_i, branch_oor_i, interp_done_i, interp_repeat_i, interp_step_i,
        start_wr_i} = ev;
    caeh_top #(.DEB_NS(200)) i_dut (.*);
    caeh_chan_model i_chan (.*);
    // clock
    initial begin
        ref_clk_i = 0;
        forever #20 ref_clk_i = ~ref_clk_i;
    end
    // hang guard
    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            mismatches++;
            test_done;
        end
    end
    task test_done;
        if (mismatches == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task cmp(input string n, input logic [15:0] g, input logic [15:0] e);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask
    task wt(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask
    task pulse(input logic [15:0] m, input logic [15:0] v = 16'h0006);
        @(posedge ref_clk_i);
        ev <= m;
        start_val_i <= v;
        @(posedge ref_clk_i) ev <= 16'h0000;
        #1;
    endtask
    task wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk_i);
        reg_wr_i <= 1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge ref_clk_i) reg_wr_i <= 0;
    endtask
    task rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge ref_clk_i);
        reg_rd_i <= 1;
        reg_addr_i <= a;
        @(posedge ref_clk_i) reg_rd_i <= 0;
        #1 d = reg_rdata_o;
    endtask
    task stat(input logic de, input logic uc);
        for (int i = 0; i < 8 && status_valid_o !== 1'b1; i++)
            wt(1);
        cmp("status", {status_valid_o, status_de_o, status_uc_o}, {1'b1, de, uc});
    endtask
    task rst;
        @(posedge ref_clk_i) rst_i <= 1;
        wt(8);
        @(posedge ref_clk_i) rst_i <= 0;
        wt(1);
    endtask
    task t_start;
        wr(`CAEH_OFS_CTRL, 16'h0002);
        pulse(p_start);
        cmp("run", interp_run_o, 1);
        pulse(p_step);
        pulse(p_rep);
        pulse(p_rep);
        cmp("run", interp_run_o, 1);
        pulse(p_rep);
        cmp("run", interp_run_o, 0);
        stat(1, 0);
        wr(`CAEH_OFS_CTRL, 16'h0000);
        pulse(p_start);
        repeat (12) pulse(p_rep);
        cmp("run", interp_run_o, 1);
        pulse(p_boor);
        cmp("run", interp_run_o, 0);
        stat(1, 0);
        pulse(p_start, 16'h0008);
        cmp("user", user_dispatch_o, 0);
        stat(1, 0);
        wr(`CAEH_OFS_CTRL, 16'h0100);
        pulse(p_start, 16'h0008);
        cmp("user", user_dispatch_o, 1);
        pulse(p_start, 16'h0003);
        stat(1, 1);
    endtask
    task t_xfer;
        logic [15:0] d;
        pulse(p_hed);
        cmp("done", xfer_done_o, 1);
        stat(1, 0);
        pulse(p_hede);
        stat(1, 1);
        @(posedge ref_clk_i) hold_i <= 1;
        pulse(p_hede);
        wt(3);
        cmp("reattach", reattach_req_o, 1);
        @(posedge ref_clk_i) hold_i <= 0;
        stat(1, 1);
        @(posedge ref_clk_i);
        cmd_seq_active_i <= 1;
        data_done_i <= 1;
        pulse(p_disc);
        stat(1, 0);
        @(posedge ref_clk_i) hold_i <= 1;
        cmd_seq_active_i <= 0;
        pulse(p_disc);
        wt(2);
        cmp("reattach", reattach_req_o, 0);
        @(posedge ref_clk_i);
        hold_i <= 0;
        xfer_to_host_i <= 1;
        xfer_err_i <= 8'h01;
        pulse(p_stope);
        rd(`CAEH_OFS_STAT, d);
        cmp("int par", d[6:4], 3'h1);
        @(posedge ref_clk_i);
        xfer_to_host_i <= 0;
        xfer_err_i <= 8'h02;
        pulse(p_zce);
        rd(`CAEH_OFS_STAT, d);
        cmp("bus par", d[6:4], 3'h2);
        @(posedge ref_clk_i) xfer_err_i <= 8'h55;
        pulse(p_irq);
        rd(`CAEH_OFS_XERR, d);
        cmp("err reg", d, 16'h0002);
    endtask
    task t_sel;
        @(posedge ref_clk_i) sel_addr_i <= 8'h21;
        pulse(p_sel);
        cmp("sel", {abort_o, sreset_notify_o, chan_enable_o}, 3'h6);
        cmp("sel addr", sreset_addr_o, 8'h21);
        wt(10);
        cmp("sel", {sreset_notify_o, chan_enable_o}, 2'h1);
        @(posedge ref_clk_i) sel_not_ready_i <= 1;
        pulse(p_sel);
        cmp("sel", {abort_o, chan_enable_o}, 2'h1);
        @(posedge ref_clk_i) sel_not_ready_i <= 0;
    endtask
    task t_key;
        logic [15:0] d;
        @(posedge ref_clk_i) disable_key_i <= 1;
        wt(2);
        @(posedge ref_clk_i) disable_key_i <= 0;
        repeat (12) begin
            wt(1);
            cmp("enable", chan_enable_o, 1);
        end
        @(posedge ref_clk_i);
        chan_irq_pending_i <= 1;
        disable_key_i <= 1;
        wt(15);
        rd(`CAEH_OFS_STAT, d);
        cmp("drain", {chan_enable_o, d[2]}, 2'h3);
        @(posedge ref_clk_i) chan_irq_pending_i <= 0;
        wt(4);
        cmp("enable", chan_enable_o, 0);
        pulse(p_hed);
        cmp("done", xfer_done_o, 0);
        rd(`CAEH_OFS_STAT, d);
        cmp("key", d[1], 1);
        @(posedge ref_clk_i) disable_key_i <= 0;
        wt(15);
        cmp("enable", chan_enable_o, 1);
    endtask
    task t_err;
        logic [15:0] d;
        @(posedge ref_clk_i) fault_code_i <= 8'h5a;
        pulse(p_flt);
        cmp("enable", chan_enable_o, 0);
        pulse(p_start);
        cmp("run", interp_run_o, 0);
        wr(`CAEH_OFS_CTRL, 16'h8000);
        wt(1);
        cmp("enable", chan_enable_o, 1);
        for (int i = 0; i < 19; i++) begin
            pulse(p_par);
            cmp("retry", retry_o, 1);
        end
        pulse(p_par);
        cmp("retry", {retry_o, chan_enable_o}, 2'h0);
        rd(`CAEH_OFS_DIAG, d);
        cmp("count", d[12:8], 5'd20);
        cmp("code", d[7:0], 8'h5a);
        wr(`CAEH_OFS_CTRL, 16'h8000);
        pulse(p_par);
        cmp("retry", {retry_o, chan_enable_o}, 2'h0);
        rd(`CAEH_OFS_DIAG, d);
        cmp("count", d[12:8], 5'd20);
        rst;
        rd(`CAEH_OFS_DIAG, d);
        cmp("count", d[12:8], 5'd0);
    endtask
    // main sequence
    initial begin
        {rst_i, reg_wr_i, reg_rd_i, disable_key_i, chan_irq_pending_i, xfer_to_host_i} = '0;
        {cmd_seq_active_i, data_done_i, sel_not_ready_i, err_cause_i, hold_i} = '0;
        {reg_addr_i, xfer_err_i, fault_code_i, sel_addr_i, reg_wdata_i, ev} = '0;
        start_val_i = 16'h0000;
        slow_i = 1;
        rst;
        wr(`CAEH_OFS_STAT, 16'hffff);
        rd(8'h10, rdv);
        cmp("unmapped", rdv, 16'h0000);
        t_start;
        t_xfer;
        t_sel;
        t_key;
        t_err;
        test_done;
    end
endmodule
